// ==== hw/tpo_params.svh ====
// Register map, field positions, reset values and divider constants
`ifndef TPO_PARAMS_SVH
`define TPO_PARAMS_SVH

`define TPO_ADDR_TRIG       8'h57
`define TPO_ADDR_OVR        8'h58
`define TPO_ADDR_TRIM       8'h59

`define TPO_TRIG_RESET      8'h00
`define TPO_OVR_RESET       8'h00
`define TPO_TRIM_RESET      8'h00

`define TPO_TRIG_EN_BIT     7
`define TPO_TRIG_MODE_MSB   2
`define TPO_TRIG_MODE_LSB   0
`define TPO_OVR_EN_BIT      7
`define TPO_DIVD_MSB        5
`define TPO_DIVD_LSB        4
`define TPO_DIVC_MSB        3
`define TPO_DIVC_LSB        2
`define TPO_SE_BIT          1
`define TPO_PLLEN_BIT       0
`define TPO_TRIM_MSB        6

// Trigger source codes
`define TPO_MODE_UI16       3'h0
`define TPO_MODE_UI64       3'h2
`define TPO_MODE_TSTAMP     3'h3

// Half period of 16 UI is 8 UI = 2**3 serializer cycles
`define TPO_TRIG_BASE_LOG2  3
// Divide-by-2 toggles on every rising reference edge = 2**0
`define TPO_REF_BASE_LOG2   0
`define TPO_DIV_CW          6

`endif

// ==== hw/tpo_pkg.sv ====
// Types shared by the trigger output and PLL override logic
package tpo_pkg;
    typedef enum logic [1:0] {
        TPO_DR_OFF,
        TPO_DR_DIV1,
        TPO_DR_DIV2,
        TPO_DR_DIV4
    } tpo_divref_e;
endpackage : tpo_pkg

// ==== hw/tpo_div_if.sv ====
// Control and output of one clock divider
`timescale 1ns/1ps
interface tpo_div_if;
    logic       run;
    logic [1:0] sel;
    logic       step;
    logic       out;
    modport ctrl (output run, output sel, output step, input out);
    modport div  (input run, input sel, input step, output out);
endinterface : tpo_div_if

// ==== hw/tpo_divider.sv ====
// Toggle divider: output flips after 2**(BASE_LOG2+sel) step pulses
`timescale 1ns/1ps
`include "tpo_params.svh"
module tpo_divider #(
    parameter int BASE_LOG2 = `TPO_TRIG_BASE_LOG2,
    parameter int CW        = `TPO_DIV_CW
) (
    input  wire logic clk,
    input  wire logic rst_b,
    tpo_div_if.div    dif
);
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          out_q;
    logic          out_d;
    logic [CW-1:0] limit;

    always_comb begin
        limit = CW'((1 << (BASE_LOG2 + int'(dif.sel))) - 1);
        cnt_d = cnt_q;
        out_d = out_q;
        // Stopped divider restarts phase-aligned from a low level
        if (!dif.run) begin
            cnt_d = '0;
            out_d = 1'b0;
        end else if (dif.step) begin
            if (cnt_q >= limit) begin
                cnt_d = '0;
                out_d = ~out_q;
            end else begin
                cnt_d = cnt_q + CW'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= '0;
            out_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            out_q <= out_d;
        end
    end

    assign dif.out = out_q;
endmodule : tpo_divider

// ==== hw/tpo_top.sv ====
// Trigger output source selection and PLL pin override registers
//
// Summary of operation
// - Enable bit 7 turns trigger output buffer on, and the divider in modes 0-2, else off.
// - Mode 0/1/2 give 16/32/64 UI clocks, 3 timestamp, 4-7 reserved.
// - Modes up to 2 derive from serializer clock; reinit interrupts them.
// - Override bit 7 picks register fields over configuration pins.
// - Bits 5:4 set second divided output: off, /1, /2, /4 under override.
// - Second divided output never clocks unless the first one clocks.
// - Bits 3:2 set first divided output: off, /1, /2, /4 under override.
// - Under override, bit 1 selects the single-ended reference input.
// - Under override, bit 0 enables the PLL instead of the pin.
// - Trim register holds 7-bit value, set by calibration or software.
`timescale 1ns/1ps
`include "tpo_params.svh"
module tpo_top (
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Register port behind the serial control interface
    input  wire logic       reg_wr_en,
    input  wire logic       reg_rd_en,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // Calibration engine access to the trim value
    input  wire logic       cal_trim_load,
    input  wire logic [6:0] cal_trim_value,
    output logic      [6:0] oscillator_trim_value,
    // Serializer reinitialisation in progress
    input  wire logic       ser_reinit,
    // Asynchronous pins
    input  wire logic       timestamp_input,
    input  wire logic       pll_ref_clock_in,
    input  wire logic       pll_enable_pin,
    input  wire logic       ref_type_pin,
    input  wire logic       clock_config_pin_a,
    input  wire logic       clock_config_pin_b,
    // Outputs
    output logic            trigger_output_pin,
    output logic            trigger_buffer_on,
    output logic            first_divref_output,
    output logic            second_divref_output,
    output logic            pll_enable_out,
    output logic            single_ended_ref_select
);
    import tpo_pkg::*;

    function automatic tpo_divref_e to_divref(input logic [1:0] bits);
        return tpo_divref_e'(bits);
    endfunction : to_divref

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    localparam int NP = 6;
    logic [NP-1:0] pin_raw;
    logic [NP-1:0] sync1_q;
    logic [NP-1:0] sync2_q;
    logic          ref_prev_q;
    logic          ref_prev_d;

    assign pin_raw = {timestamp_input, pll_ref_clock_in, pll_enable_pin,
                      ref_type_pin, clock_config_pin_b, clock_config_pin_a};

    always_comb begin
        ref_prev_d = sync2_q[4];
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_q    <= '0;
            sync2_q    <= '0;
            ref_prev_q <= 1'b0;
        end else begin
            sync1_q    <= pin_raw;
            sync2_q    <= sync1_q;
            ref_prev_q <= ref_prev_d;
        end
    end

    logic       ts_s;
    logic       ref_s;
    logic       ref_rise;
    logic [1:0] cfg_s;
    assign ts_s     = sync2_q[5];
    assign ref_s    = sync2_q[4];
    assign cfg_s    = sync2_q[1:0];
    assign ref_rise = ref_s & ~ref_prev_q;

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] trig_q, trig_d;
    logic [7:0] ovr_q, ovr_d;
    logic [6:0] trim_q, trim_d;
    logic [7:0] rdata_q, rdata_d;

    always_comb begin
        trig_d  = trig_q;
        ovr_d   = ovr_q;
        trim_d  = trim_q;
        rdata_d = rdata_q;
        if (reg_wr_en) begin
            // Reserved bits are not stored and read back as zero
            unique case (reg_addr)
                `TPO_ADDR_TRIG: trig_d = reg_wdata & 8'h87;
                `TPO_ADDR_OVR:  ovr_d  = reg_wdata & 8'hbf;
                `TPO_ADDR_TRIM: trim_d = reg_wdata[`TPO_TRIM_MSB:0];
                default: ;
            endcase
        end
        // Calibration result overrides a same-cycle software write
        if (cal_trim_load) begin
            trim_d = cal_trim_value;
        end
        if (reg_rd_en) begin
            unique case (reg_addr)
                `TPO_ADDR_TRIG: rdata_d = trig_q;
                `TPO_ADDR_OVR:  rdata_d = ovr_q;
                `TPO_ADDR_TRIM: rdata_d = {1'b0, trim_q};
                default:        rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            trig_q  <= `TPO_TRIG_RESET;
            ovr_q   <= `TPO_OVR_RESET;
            trim_q  <= 7'(`TPO_TRIM_RESET);
            rdata_q <= 8'h00;
        end else begin
            trig_q  <= trig_d;
            ovr_q   <= ovr_d;
            trim_q  <= trim_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata             = rdata_q;
    assign oscillator_trim_value = trim_q;

    ////////////////////////////////////////////////////////////////////////
    // Dividers
    tpo_div_if trig_if ();
    tpo_div_if divc_if ();
    tpo_div_if divd_if ();

    logic        trig_en;
    logic [2:0]  trig_mode;
    logic        ovr_en;
    tpo_divref_e divc_mode;
    tpo_divref_e divd_mode;

    assign trig_en   = trig_q[`TPO_TRIG_EN_BIT];
    assign trig_mode = trig_q[`TPO_TRIG_MODE_MSB:`TPO_TRIG_MODE_LSB];
    assign ovr_en    = ovr_q[`TPO_OVR_EN_BIT];

    always_comb begin
        // Source picked by override bit
        if (ovr_en) begin
            divc_mode = to_divref(ovr_q[`TPO_DIVC_MSB:`TPO_DIVC_LSB]);
            divd_mode = to_divref(ovr_q[`TPO_DIVD_MSB:`TPO_DIVD_LSB]);
        end else begin
            // Pin mode: first output follows pins, second tracks above /1
            divc_mode = to_divref(cfg_s);
            divd_mode = (cfg_s[1]) ? to_divref(cfg_s) : TPO_DR_OFF;
        end
        if (divc_mode == TPO_DR_OFF) begin
            divd_mode = TPO_DR_OFF;
        end
    end

    // Serializer reinit stops the UI divider, so the output holds low
    assign trig_if.run  = trig_en && (trig_mode <= `TPO_MODE_UI64)
                          && !ser_reinit;
    assign trig_if.sel  = trig_mode[1:0];
    assign trig_if.step = 1'b1;

    assign divc_if.run  = divc_mode inside {TPO_DR_DIV2, TPO_DR_DIV4};
    assign divc_if.sel  = {1'b0, divc_mode == TPO_DR_DIV4};
    assign divc_if.step = ref_rise;
    assign divd_if.run  = divd_mode inside {TPO_DR_DIV2, TPO_DR_DIV4};
    assign divd_if.sel  = {1'b0, divd_mode == TPO_DR_DIV4};
    assign divd_if.step = ref_rise;

    tpo_divider #(.BASE_LOG2(`TPO_TRIG_BASE_LOG2), .CW(`TPO_DIV_CW))
        u_trig_div (.clk(clk), .rst_b(rst_b), .dif(trig_if));
    tpo_divider #(.BASE_LOG2(`TPO_REF_BASE_LOG2), .CW(`TPO_DIV_CW))
        u_divc (.clk(clk), .rst_b(rst_b), .dif(divc_if));
    tpo_divider #(.BASE_LOG2(`TPO_REF_BASE_LOG2), .CW(`TPO_DIV_CW))
        u_divd (.clk(clk), .rst_b(rst_b), .dif(divd_if));

    ////////////////////////////////////////////////////////////////////////
    // Output stage
    logic trig_out_q, trig_out_d;
    logic buf_on_q, buf_on_d;
    logic divc_out_q, divc_out_d;
    logic divd_out_q, divd_out_d;
    logic pll_en_q, pll_en_d;
    logic se_q, se_d;

    function automatic logic divref_level(input tpo_divref_e m,
                                          input logic ref_lvl,
                                          input logic div_lvl);
        unique case (m)
            TPO_DR_OFF:  return 1'b0;
            TPO_DR_DIV1: return ref_lvl;
            TPO_DR_DIV2,
            TPO_DR_DIV4: return div_lvl;
        endcase
        return 1'b0;
    endfunction : divref_level

    always_comb begin
        buf_on_d   = trig_en;
        trig_out_d = 1'b0;
        if (trig_en) begin
            if (trig_mode <= `TPO_MODE_UI64) begin
                trig_out_d = trig_if.out;
            end else if (trig_mode == `TPO_MODE_TSTAMP) begin
                trig_out_d = ts_s;
            end else begin
                trig_out_d = 1'b0;
            end
        end
        divc_out_d = divref_level(divc_mode, ref_s, divc_if.out);
        divd_out_d = divref_level(divd_mode, ref_s, divd_if.out);
        pll_en_d   = ovr_en ? ovr_q[`TPO_PLLEN_BIT] : sync2_q[3];
        se_d       = ovr_en ? ovr_q[`TPO_SE_BIT] : sync2_q[2];
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            trig_out_q <= 1'b0;
            buf_on_q   <= 1'b0;
            divc_out_q <= 1'b0;
            divd_out_q <= 1'b0;
            pll_en_q   <= 1'b0;
            se_q       <= 1'b0;
        end else begin
            trig_out_q <= trig_out_d;
            buf_on_q   <= buf_on_d;
            divc_out_q <= divc_out_d;
            divd_out_q <= divd_out_d;
            pll_en_q   <= pll_en_d;
            se_q       <= se_d;
        end
    end

    assign trigger_output_pin      = trig_out_q;
    assign trigger_buffer_on       = buf_on_q;
    assign first_divref_output     = divc_out_q;
    assign second_divref_output    = divd_out_q;
    assign pll_enable_out          = pll_en_q;
    assign single_ended_ref_select = se_q;
endmodule : tpo_top

// ==== verif/tpo_far_end.sv ====
// Far-end model: clock sources and edge meters
`timescale 1ns/1ps
module tpo_far_end (
    input  wire logic             clk,
    input  wire logic [2:0]       sense,
    output logic                  ref_clk,
    output logic                  tstamp,
    output logic [2:0][7:0]       gap,
    output logic [2:0][15:0]      edges
);
    logic [2:0]      last;
    logic [2:0][7:0] run;
    // Free-running sources, phase unrelated to clk
    initial begin
        ref_clk = 1'b0;
        #3;
        forever #40 ref_clk = ~ref_clk;
    end
    initial begin
        tstamp = 1'b0;
        #7;
        forever #100 tstamp = ~tstamp;
    end
    initial begin
        last  = '0;
        run   = '0;
        gap   = '0;
        edges = '0;
    end
    // Gap is the cycle count between two changes of a sensed output
    // Sampled mid-cycle, where the registered outputs have settled
    always @(negedge clk) begin
        for (int i = 0; i < 3; i++) begin
            if (sense[i] !== last[i]) begin
                gap[i]   <= run[i] + 8'h01;
                run[i]   <= 8'h00;
                edges[i] <= edges[i] + 16'h0001;
            end else begin
                run[i] <= run[i] + 8'h01;
            end
        end
        last <= sense;
    end
endmodule : tpo_far_end

// ==== verif/tpo_top_sva.sv ====
// Port checker for trigger source and PLL override
`timescale 1ns/1ps
module tpo_top_sva (
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       reg_wr_en,
    input wire logic       reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       cal_trim_load,
    input wire logic [6:0] cal_trim_value,
    input wire logic [6:0] oscillator_trim_value,
    input wire logic       trigger_output_pin,
    input wire logic       trigger_buffer_on,
    input wire logic       first_divref_output,
    input wire logic       second_divref_output,
    input wire logic       pll_enable_out,
    input wire logic       single_ended_ref_select
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic [7:0] idle_q, idle_d;
    logic       first_q;
    // Saturating count of cycles the first output has not moved
    always_comb begin
        idle_d = idle_q;
        if (first_divref_output != first_q)
            idle_d = 8'h00;
        else if (idle_q != 8'hff)
            idle_d = idle_q + 8'h01;
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            idle_q  <= 8'h00;
            first_q <= 1'b0;
        end else begin
            idle_q  <= idle_d;
            first_q <= first_divref_output;
        end
    end
    sequence wr_s(a);
        reg_wr_en && reg_addr == a;
    endsequence
    trig_buf_a: assert property (
        wr_s(8'h57) |-> ##2 trigger_buffer_on == $past(reg_wdata[7], 2))
        else $error("trigger buffer enable wrong");
    trig_off_a: assert property (
        !trigger_buffer_on [*2] |-> !trigger_output_pin)
        else $error("trigger active while disabled");
    resv_mode_a: assert property (
        wr_s(8'h57) ##0 (reg_wdata[7] && reg_wdata[2])
        |-> ##3 !trigger_output_pin [*8])
        else $error("reserved mode gave a clock");
    divref_pair_a: assert property (
        idle_q >= 8'h28 && first_divref_output == first_q
        |-> !second_divref_output)
        else $error("second output alone");
    pll_en_a: assert property (
        wr_s(8'h58) ##0 reg_wdata[7]
        |-> ##2 pll_enable_out == $past(reg_wdata[0], 2))
        else $error("override pll enable wrong");
    se_sel_a: assert property (
        wr_s(8'h58) ##0 reg_wdata[7]
        |-> ##2 single_ended_ref_select == $past(reg_wdata[1], 2))
        else $error("override ref select wrong");
    trim_rd_a: assert property (
        reg_rd_en && reg_addr == 8'h59
        |=> reg_rdata == {1'b0, $past(oscillator_trim_value)})
        else $error("trim readback wrong");
    trim_cal_a: assert property (
        cal_trim_load |=> oscillator_trim_value == $past(cal_trim_value))
        else $error("calibration trim not stored");
endmodule : tpo_top_sva
bind tpo_top tpo_top_sva i_sva (.clk, .rst_b, .reg_wr_en, .reg_rd_en,
    .reg_addr, .reg_wdata, .reg_rdata, .cal_trim_load, .cal_trim_value,
    .oscillator_trim_value, .trigger_output_pin, .trigger_buffer_on,
    .first_divref_output, .second_divref_output, .pll_enable_out,
    .single_ended_ref_select);

// ==== verif/tpo_top_test.sv ====
// Register-level test of trigger source and PLL override
`timescale 1ns/1ps
module tpo_top_test;
    logic clk, rst_b, wr, rd, ld, reinit, pen, rtp, cfa, cfb;
    logic trig, tbuf, fdr, sdr, plo, sel, refc, ts;
    logic [7:0] addr, wdat, rdat;
    logic [6:0] cval, trim;
    logic [2:0][7:0]  gap;
    logic [2:0][15:0] edg, e0;
    int bad_count, checked;
    tpo_top i_dut (.clk(clk), .rst_b(rst_b), .reg_wr_en(wr),
        .reg_rd_en(rd), .reg_addr(addr), .reg_wdata(wdat),
        .reg_rdata(rdat), .cal_trim_load(ld), .cal_trim_value(cval),
        .oscillator_trim_value(trim), .ser_reinit(reinit),
        .timestamp_input(ts), .pll_ref_clock_in(refc),
        .pll_enable_pin(pen), .ref_type_pin(rtp),
        .clock_config_pin_a(cfa), .clock_config_pin_b(cfb),
        .trigger_output_pin(trig), .trigger_buffer_on(tbuf),
        .first_divref_output(fdr), .second_divref_output(sdr),
        .pll_enable_out(plo), .single_ended_ref_select(sel));
    tpo_far_end i_far (.clk(clk), .sense({sdr, fdr, trig}),
        .ref_clk(refc), .tstamp(ts), .gap(gap), .edges(edg));
    always #5 clk = ~clk;
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic wr_reg(logic [7:0] a, logic [7:0] d);
        @(negedge clk);
        wr   = 1'b1;
        addr = a;
        wdat = d;
        @(negedge clk);
        wr = 1'b0;
    endtask : wr_reg
    task automatic rd_chk(logic [7:0] a, logic [7:0] e);
        @(negedge clk);
        rd   = 1'b1;
        addr = a;
        @(negedge clk);
        rd = 1'b0;
        chk("rdata", {8'h00, e}, {8'h00, rdat});
    endtask : rd_chk
    // Settle, then count edges over a fixed window
    task automatic meas;
        repeat (100) @(negedge clk);
        e0 = edg;
        repeat (100) @(negedge clk);
    endtask : meas
    task automatic end_of_test;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////////
    initial begin
        {clk, rst_b, wr, rd, ld, reinit, pen, rtp, cfa, cfb} = '0;
        {addr, wdat, cval} = '0;
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        rd_chk(8'h57, 8'h00);
        rd_chk(8'h58, 8'h00);
        rd_chk(8'h59, 8'h00);
        rd_chk(8'h5a, 8'h00);
        wr_reg(8'h59, 8'h55);
        rd_chk(8'h59, 8'h55);
        @(negedge clk);
        ld   = 1'b1;
        cval = 7'h2a;
        @(negedge clk);
        ld = 1'b0;
        rd_chk(8'h59, 8'h2a);
        for (int m = 0; m < 8; m++) begin
            wr_reg(8'h57, 8'(m));
            wr_reg(8'h57, 8'h80 | 8'(m));
            meas();
            chk("tbuf", 16'h0001, {15'h0, tbuf});
            if (m == 3)
                chk("tgap", 16'd10, {8'h0, gap[0]});
            else if (m < 3)
                chk("tgap", 16'd8 << m, {8'h0, gap[0]});
            else
                chk("tedge", 16'h0, edg[0] - e0[0]);
            wr_reg(8'h57, 8'h00);
        end
        wr_reg(8'h57, 8'h80);
        reinit = 1'b1;
        meas();
        chk("reinit", 16'h0, {edg[0] - e0[0]} | {15'h0, trig});
        reinit = 1'b0;
        meas();
        chk("restart", 16'd8, {8'h0, gap[0]});
        for (int c = 0; c < 4; c++) begin
            for (int d = 0; d < 4; d++) begin
                wr_reg(8'h58, 8'h83 | 8'(d << 4) | 8'(c << 2));
                meas();
                chk("pll", 16'h0003, {14'h0, sel, plo});
                chk("c_edge", 16'(c != 0), 16'(edg[1] != e0[1]));
                chk("d_edge", 16'(c && d), 16'(edg[2] != e0[2]));
                if (c != 0)
                    chk("c_gap", 16'd2 << c, {8'h0, gap[1]});
                if (c != 0 && d != 0)
                    chk("d_gap", 16'd2 << d, {8'h0, gap[2]});
            end
        end
        wr_reg(8'h58, 8'h3f);
        rd_chk(8'h58, 8'h3f);
        pen = 1'b1;
        cfb = 1'b1;
        meas();
        chk("pin_pll", 16'h0001, {14'h0, sel, plo});
        chk("pin_gap", 16'h0808, {gap[2], gap[1]});
        {pen, rtp, cfb, cfa} = 4'b0111;
        meas();
        chk("pin_se", 16'h0002, {14'h0, sel, plo});
        chk("pin_div4", 16'h1010, {gap[2], gap[1]});
        cfb = 1'b0;
        meas();
        chk("pin_div1", 16'h0004, {8'h0, gap[1]});
        chk("pin_d_off", 16'h0, edg[2] - e0[2]);
        cfa = 1'b0;
        meas();
        chk("pin_off", 16'h0, (edg[1] - e0[1]) | (edg[2] - e0[2]));
        end_of_test();
    end
endmodule : tpo_top_test
